// ==== dv/core_model.sv ====
// Core-side model that issues stack operations and data accesses to the guard.
`timescale 1ns/10ps
module core_model (
  input  wire logic                              clk,
  output logic                                   sp_wr,
  output logic [15:0]                            sp_wdata,
  output logic                                   op_valid,
  output logic [1:0]                             op_kind,
  output logic [1:0]                             push_src,
  output logic [15:0]                            push_data,
  output logic [15:0]                            ref_ea,
  output logic [stack_guard_pkg::PC_W-1:0]       pc,
  output logic [7:0]                             status_low,
  output logic                                   data_access,
  output logic [15:0]                            data_addr
);
  initial begin
    {sp_wr, sp_wdata, op_valid, op_kind, push_src, push_data, ref_ea} = '0;
    {pc, status_low, data_access, data_addr} = '0;
  end

  // Released push_data, ref_ea, sp_wdata and data_addr carry the inverse of their last value, so stale data is never read as valid.
  task automatic issue(input logic [1:0] kind, input logic [1:0] src, input logic [15:0] val,
                       input logic [stack_guard_pkg::PC_W-1:0] pc_v, input logic [7:0] sl);
    @(posedge clk);
    op_valid   <= 1'b1;
    op_kind    <= kind;
    push_src   <= src;
    push_data  <= val;
    ref_ea     <= val;
    pc         <= pc_v;
    status_low <= sl;
    @(posedge clk);
    op_valid   <= 1'b0;
    push_data  <= ~val;
    ref_ea     <= ~val;
  endtask

  task automatic sp_write(input logic [15:0] val);
    @(posedge clk);
    sp_wr    <= 1'b1;
    sp_wdata <= val;
    @(posedge clk);
    sp_wr    <= 1'b0;
    sp_wdata <= ~val;
  endtask

  task automatic access(input logic [15:0] a, input logic [stack_guard_pkg::PC_W-1:0] pc_v);
    @(posedge clk);
    data_access <= 1'b1;
    data_addr   <= a;
    pc          <= pc_v;
    @(posedge clk);
    data_access <= 1'b0;
    data_addr   <= ~a;
  endtask
endmodule // core_model

// ==== dv/tb_top.sv ====
// Self-checking testbench for the stack limit guard.
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [1:0]  kind;
    logic [1:0]  src;
    logic [15:0] val;
    logic [22:0] pc;
    logic [7:0]  sl;
    logic [15:0] addr;
    logic [15:0] wd;
    logic [15:0] hi;
    logic        trap;
    logic [15:0] sp;
  } row_t;

  logic        ref_clk, rst_n, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sp_wr, op_valid, data_access, busy, mem_wr, mem_rd;
  logic        trap_req, access_deny;
  logic [1:0]  op_kind, push_src;
  logic [15:0] sp_wdata, push_data, ref_ea, data_addr, stack_ptr, mem_addr, mem_wdata;
  logic [22:0] pc;
  logic [7:0]  status_low;
  int          n_errors = 0;
  int          n_checks = 0;

  // Kind 1 push, 2 pop, 3 other pointer use; source 1 call, 2 exception.
  row_t rows [10] = '{
    '{2'h1, 2'h0, 16'h1234, 23'h0, 8'h00, 16'h0800, 16'h1234, 16'h0000, 1'b0, 16'h0802},
    '{2'h1, 2'h0, 16'hbeef, 23'h0, 8'h00, 16'h0802, 16'hbeef, 16'h0000, 1'b0, 16'h0804},
    '{2'h2, 2'h0, 16'h0000, 23'h0, 8'h00, 16'h0802, 16'h0000, 16'h0000, 1'b0, 16'h0802},
    '{2'h2, 2'h0, 16'h0000, 23'h0, 8'h00, 16'h0800, 16'h0000, 16'h0000, 1'b0, 16'h0800},
    '{2'h2, 2'h0, 16'h0000, 23'h0, 8'h00, 16'h07fe, 16'h0000, 16'h0000, 1'b1, 16'h07fe},
    '{2'h1, 2'h0, 16'h5a5a, 23'h0, 8'h00, 16'h07fe, 16'h5a5a, 16'h0000, 1'b1, 16'h0800},
    '{2'h1, 2'h1, 16'h0000, 23'h412345, 8'h00, 16'h0800, 16'h2345, 16'h0041, 1'b0, 16'h0804},
    '{2'h1, 2'h2, 16'h0000, 23'h7abcde, 8'hff, 16'h0804, 16'hbcde, 16'hff7a, 1'b0, 16'h0808},
    '{2'h3, 2'h0, 16'h07fc, 23'h0, 8'h00, 16'h0000, 16'h0000, 16'h0000, 1'b1, 16'h0808},
    '{2'h3, 2'h0, 16'h0900, 23'h0, 8'h00, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h0808}
  };

  stack_limit_guard uut (
    .REF_CLK(ref_clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SP_WR(sp_wr), .SP_WDATA(sp_wdata), .OP_VALID(op_valid), .OP_KIND(op_kind),
    .PUSH_SRC(push_src), .PUSH_DATA(push_data), .REF_EA(ref_ea), .PC(pc),
    .STATUS_LOW(status_low), .DATA_ACCESS(data_access), .DATA_ADDR(data_addr),
    .STACK_PTR(stack_ptr), .BUSY(busy), .MEM_WR(mem_wr), .MEM_RD(mem_rd),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .TRAP_REQ(trap_req), .ACCESS_DENY(access_deny)
  );

  core_model core (
    .clk(ref_clk), .sp_wr(sp_wr), .sp_wdata(sp_wdata), .op_valid(op_valid),
    .op_kind(op_kind), .push_src(push_src), .push_data(push_data), .ref_ea(ref_ea),
    .pc(pc), .status_low(status_low), .data_access(data_access), .data_addr(data_addr)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic exp_err);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    if (!wr) chk(prdata, exp);
    chk(pslverr, exp_err);
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd;
  endtask

  // Outputs are sampled at the edge ending each answer cycle.
  task automatic run_row(input row_t r);
    logic pc_push;
    pc_push = (r.kind == 2'h1) && (r.src != 2'h0);
    core.issue(r.kind, r.src, r.val, r.pc, r.sl);
    @(posedge ref_clk);
    chk(mem_wr, r.kind == 2'h1);
    chk(mem_rd, r.kind == 2'h2);
    chk(trap_req, r.trap);
    chk(busy, pc_push);
    if (r.kind == 2'h1 || r.kind == 2'h2) chk(mem_addr, r.addr);
    if (r.kind == 2'h1) chk(mem_wdata, r.wd);
    if (pc_push) begin
      @(posedge ref_clk);
      chk(mem_addr, r.addr + 16'h0002);
      chk(mem_wdata, r.hi);
    end
    chk(stack_ptr, r.sp);
    @(posedge ref_clk);
    chk(trap_req, 1'b0);
  endtask

  initial begin
    rst_n   = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(stack_ptr, stack_guard_pkg::SP_RESET);
    chk(trap_req, 1'b0);
    apb(1'b0, stack_guard_pkg::REG_LIMIT, 32'h0, 32'h0, 1'b0);
    apb(1'b0, stack_guard_pkg::REG_PROT, 32'h0, 32'h0, 1'b0);
    foreach (rows[i]) run_row(rows[i]);
    apb(1'b0, stack_guard_pkg::REG_STATUS, 32'h0, 32'h2, 1'b0);
    apb(1'b1, stack_guard_pkg::REG_STATUS, 32'h3, 32'h0, 1'b0);
    apb(1'b0, stack_guard_pkg::REG_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h10, 32'hffff, 32'h0, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b0, stack_guard_pkg::REG_POINTER, 32'h0, 32'h0808, 1'b0);
    apb(1'b1, stack_guard_pkg::REG_LIMIT, 32'h080b, 32'h0, 1'b0);
    apb(1'b0, stack_guard_pkg::REG_LIMIT, 32'h0, 32'h080a, 1'b0);
    @(posedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      run_row('{2'h1, 2'h0, 16'h00a0, 23'h0, 8'h00, 16'h0808 + 16'(2 * i), 16'h00a0,
                16'h0000, i == 2, 16'h080a + 16'(2 * i)});
    end
    apb(1'b0, stack_guard_pkg::REG_STATUS, 32'h0, 32'h1, 1'b0);
    core.sp_write(16'h0a03);
    @(posedge ref_clk);
    chk(stack_ptr, 16'h0a02);
    apb(1'b1, stack_guard_pkg::REG_PROT, 32'h3, 32'h0, 1'b0);
    apb(1'b0, stack_guard_pkg::REG_PROT, 32'h0, 32'h3, 1'b0);
    core.access(16'h0850, 23'h000100);
    @(posedge ref_clk);
    chk(access_deny, 1'b1);
    core.access(16'h0850, 23'h000300);
    @(posedge ref_clk);
    chk(access_deny, 1'b0);
    core.access(16'h0950, 23'h000300);
    @(posedge ref_clk);
    chk(access_deny, 1'b1);
    core.access(16'h0950, 23'h000900);
    @(posedge ref_clk);
    chk(access_deny, 1'b0);
    apb(1'b1, stack_guard_pkg::REG_PROT, 32'h0, 32'h0, 1'b0);
    core.access(16'h0850, 23'h000100);
    @(posedge ref_clk);
    chk(access_deny, 1'b0);
    // Mid-run reset: pointer returns home and the limit reads zero again.
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(stack_ptr, stack_guard_pkg::SP_RESET);
    chk(trap_req, 1'b0);
    apb(1'b0, stack_guard_pkg::REG_LIMIT, 32'h0, 32'h0, 1'b0);
    apb(1'b0, stack_guard_pkg::REG_STATUS, 32'h0, 32'h0, 1'b0);
    finish_test();
  end

  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
endmodule // tb_top

// ==== verilog/ram_segment_gate.sv ====
// Secure RAM segment gate: flags data accesses made from the wrong flash segment.
`timescale 1ns/10ps
module ram_segment_gate (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              access,
  input  wire logic [15:0]                       addr,
  input  wire logic [stack_guard_pkg::PC_W-1:0]  pc,
  input  wire logic                              boot_en,
  input  wire logic                              seg_en,
  output logic                                   deny
);

  logic deny_reg;
  logic deny_next;
  logic boot_bad;
  logic seg_bad;

  function automatic logic in_ram(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_ram = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_flash(input logic [stack_guard_pkg::PC_W-1:0] a,
                                    input logic [stack_guard_pkg::PC_W-1:0] lo,
                                    input logic [stack_guard_pkg::PC_W-1:0] hi);
    in_flash = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    boot_bad = boot_en
      && in_ram(addr, stack_guard_pkg::BOOT_RAM_LO, stack_guard_pkg::BOOT_RAM_HI)
      && !in_flash(pc, stack_guard_pkg::BOOT_FLASH_LO, stack_guard_pkg::BOOT_FLASH_HI);
    seg_bad = seg_en
      && in_ram(addr, stack_guard_pkg::SEG_RAM_LO, stack_guard_pkg::SEG_RAM_HI)
      && !in_flash(pc, stack_guard_pkg::SEG_FLASH_LO, stack_guard_pkg::SEG_FLASH_HI);
    deny_next = access && (boot_bad || seg_bad);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deny_reg <= 1'b0;
    end else begin
      deny_reg <= deny_next;
    end
  end

  assign deny = deny_reg;

  property p_boot_gate;
    @(posedge clk) disable iff (!rst_n)
      access && boot_en && addr >= stack_guard_pkg::BOOT_RAM_LO
      && addr <= stack_guard_pkg::BOOT_RAM_HI
      && (pc < stack_guard_pkg::BOOT_FLASH_LO || pc > stack_guard_pkg::BOOT_FLASH_HI)
      |=> deny;
  endproperty
  a_boot_gate: assert property (p_boot_gate) else $error("Boot RAM access not denied.");

  property p_seg_gate;
    @(posedge clk) disable iff (!rst_n)
      access && seg_en && addr >= stack_guard_pkg::SEG_RAM_LO
      && addr <= stack_guard_pkg::SEG_RAM_HI
      && pc >= stack_guard_pkg::SEG_FLASH_LO && pc <= stack_guard_pkg::SEG_FLASH_HI
      |=> !deny;
  endproperty
  a_seg_gate: assert property (p_seg_gate) else $error("Secure RAM access wrongly denied.");

endmodule // ram_segment_gate

// ==== verilog/stack_guard_pkg.sv ====
// Constants, register map and types shared by the stack limit guard files.
package stack_guard_pkg;

  localparam int PC_W = 23;

  // APB register byte offsets.
  localparam logic [7:0] REG_LIMIT   = 8'h00;
  localparam logic [7:0] REG_POINTER = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_PROT    = 8'h0c;

  // Field positions and the flag field width.
  localparam int FLAG_OVF = 0;
  localparam int FLAG_UNF = 1;
  localparam int PROT_BOOT = 0;
  localparam int PROT_SEG  = 1;
  localparam int FLAG_N    = 2;

  // Stack geometry.
  localparam logic [15:0] SFR_FLOOR = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] SP_RESET  = 16'h0800;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic        PC_PAD    = 1'b0;

  // Secure RAM windows and the flash segments allowed to reach them.
  localparam logic [15:0]     BOOT_RAM_LO   = 16'h0800;
  localparam logic [15:0]     BOOT_RAM_HI   = 16'h08ff;
  localparam logic [15:0]     SEG_RAM_LO    = 16'h0900;
  localparam logic [15:0]     SEG_RAM_HI    = 16'h09ff;
  localparam logic [PC_W-1:0] BOOT_FLASH_LO = 23'h000200;
  localparam logic [PC_W-1:0] BOOT_FLASH_HI = 23'h0007ff;
  localparam logic [PC_W-1:0] SEG_FLASH_LO  = 23'h000800;
  localparam logic [PC_W-1:0] SEG_FLASH_HI  = 23'h001fff;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_PUSH = 2'b01,
    OP_POP  = 2'b10,
    OP_REF  = 2'b11
  } stack_op_t;

  typedef enum logic [1:0] {
    SRC_DATA = 2'b00,
    SRC_CALL = 2'b01,
    SRC_EXC  = 2'b10
  } push_src_t;

  typedef enum logic {
    ST_IDLE    = 1'b0,
    ST_PC_HIGH = 1'b1
  } seq_state_t;

endpackage

// ==== verilog/stack_limit_guard.sv ====
// Stack pointer, stack limit checking, PC push shaping and APB registers.
`timescale 1ns/10ps
module stack_limit_guard (
  input  wire logic                              REF_CLK,
  input  wire logic                              RESETN,
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [7:0]                        PADDR,
  input  wire logic [31:0]                       PWDATA,
  output logic      [31:0]                       PRDATA,
  output logic                                   PREADY,
  output logic                                   PSLVERR,
  input  wire logic                              SP_WR,
  input  wire logic [15:0]                       SP_WDATA,
  input  wire logic                              OP_VALID,
  input  wire logic [1:0]                        OP_KIND,
  input  wire logic [1:0]                        PUSH_SRC,
  input  wire logic [15:0]                       PUSH_DATA,
  input  wire logic [15:0]                       REF_EA,
  input  wire logic [stack_guard_pkg::PC_W-1:0]  PC,
  input  wire logic [7:0]                        STATUS_LOW,
  input  wire logic                              DATA_ACCESS,
  input  wire logic [15:0]                       DATA_ADDR,
  output logic      [15:0]                       STACK_PTR,
  output logic                                   BUSY,
  output logic                                   MEM_WR,
  output logic                                   MEM_RD,
  output logic      [15:0]                       MEM_ADDR,
  output logic      [15:0]                       MEM_WDATA,
  output logic                                   TRAP_REQ,
  output logic                                   ACCESS_DENY
);

  stack_guard_pkg::seq_state_t state_reg;
  stack_guard_pkg::seq_state_t state_next;
  logic [15:0]                 sp_reg;
  logic [15:0]                 sp_next;
  logic [15:0]                 hi_word_reg;
  logic [15:0]                 hi_word_next;
  logic                        busy_reg;
  logic                        busy_next;
  logic                        mem_wr_reg;
  logic                        mem_wr_next;
  logic                        mem_rd_reg;
  logic                        mem_rd_next;
  logic [15:0]                 mem_addr_reg;
  logic [15:0]                 mem_addr_next;
  logic [15:0]                 mem_wdata_reg;
  logic [15:0]                 mem_wdata_next;
  logic                        trap_reg;
  logic                        trap_next;
  logic [15:0]                 ea;
  logic                        ea_valid;
  logic                        ovf_hit;
  logic                        unf_hit;
  logic [15:0]                 limit_reg;
  logic [15:0]                 limit_next;
  logic                        limit_valid_reg;
  logic                        limit_valid_next;
  logic [stack_guard_pkg::FLAG_N-1:0] flags_reg;
  logic [stack_guard_pkg::FLAG_N-1:0] flags_next;
  logic [stack_guard_pkg::FLAG_N-1:0] flag_hit;
  logic [stack_guard_pkg::FLAG_N-1:0] flag_clr;
  logic [stack_guard_pkg::FLAG_N-1:0] prot_reg;
  logic [stack_guard_pkg::FLAG_N-1:0] prot_next;
  logic [31:0]                 prdata_reg;
  logic [31:0]                 prdata_next;
  logic                        pready_reg;
  logic                        pready_next;
  logic                        pslverr_reg;
  logic                        pslverr_next;
  logic                        apb_setup;
  logic                        apb_write;
  logic [3:0]                  sel;

  // One-hot register select; all zero means an unmapped offset.
  function automatic logic [3:0] reg_select(input logic [7:0] a);
    reg_select = {a == stack_guard_pkg::REG_PROT, a == stack_guard_pkg::REG_STATUS,
                  a == stack_guard_pkg::REG_POINTER, a == stack_guard_pkg::REG_LIMIT};
  endfunction

  // Stack sequencer. A PC push takes two cycles: low word, then high word.
  always_comb begin
    state_next     = state_reg;
    sp_next        = sp_reg;
    hi_word_next   = hi_word_reg;
    mem_wr_next    = 1'b0;
    mem_rd_next    = 1'b0;
    mem_addr_next  = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    ea             = sp_reg;
    ea_valid       = 1'b0;
    unique case (state_reg)
      stack_guard_pkg::ST_IDLE: begin
        if (OP_VALID && OP_KIND == stack_guard_pkg::OP_PUSH) begin
          ea_valid      = 1'b1;
          mem_wr_next   = 1'b1;
          mem_addr_next = sp_reg;
          sp_next       = sp_reg + stack_guard_pkg::WORD_STEP;
          if (PUSH_SRC == stack_guard_pkg::SRC_CALL) begin
            mem_wdata_next = PC[15:0];
            hi_word_next   = {stack_guard_pkg::BYTE_ZERO, stack_guard_pkg::PC_PAD,
                              PC[stack_guard_pkg::PC_W-1:16]};
            state_next     = stack_guard_pkg::ST_PC_HIGH;
          end else if (PUSH_SRC == stack_guard_pkg::SRC_EXC) begin
            mem_wdata_next = PC[15:0];
            hi_word_next   = {STATUS_LOW, stack_guard_pkg::PC_PAD,
                              PC[stack_guard_pkg::PC_W-1:16]};
            state_next     = stack_guard_pkg::ST_PC_HIGH;
          end else begin
            mem_wdata_next = PUSH_DATA;
          end
        end else if (OP_VALID && OP_KIND == stack_guard_pkg::OP_POP) begin
          ea            = sp_reg - stack_guard_pkg::WORD_STEP;
          ea_valid      = 1'b1;
          mem_rd_next   = 1'b1;
          mem_addr_next = ea;
          sp_next       = ea;
        end else if (OP_VALID && OP_KIND == stack_guard_pkg::OP_REF) begin
          ea       = REF_EA;
          ea_valid = 1'b1;
        end else if (SP_WR) begin
          sp_next = {SP_WDATA[15:1], 1'b0};
        end
      end
      stack_guard_pkg::ST_PC_HIGH: begin
        ea_valid       = 1'b1;
        mem_wr_next    = 1'b1;
        mem_addr_next  = sp_reg;
        mem_wdata_next = hi_word_reg;
        sp_next        = sp_reg + stack_guard_pkg::WORD_STEP;
        state_next     = stack_guard_pkg::ST_IDLE;
      end
    endcase
    busy_next = (state_next == stack_guard_pkg::ST_PC_HIGH);
    // The limit is compared from its register, so a fresh write is seen one cycle later.
    ovf_hit   = ea_valid && limit_valid_reg && (ea > limit_reg);
    unf_hit   = ea_valid && (ea < stack_guard_pkg::SFR_FLOOR);
    trap_next = ovf_hit || unf_hit;
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg     <= stack_guard_pkg::ST_IDLE;
      sp_reg        <= stack_guard_pkg::SP_RESET;
      hi_word_reg   <= '0;
      busy_reg      <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_rd_reg    <= 1'b0;
      mem_addr_reg  <= '0;
      mem_wdata_reg <= '0;
      trap_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      sp_reg        <= sp_next;
      hi_word_reg   <= hi_word_next;
      busy_reg      <= busy_next;
      mem_wr_reg    <= mem_wr_next;
      mem_rd_reg    <= mem_rd_next;
      mem_addr_reg  <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      trap_reg      <= trap_next;
    end
  end

  // APB slave: no wait state, answer raised in the first access cycle.
  always_comb begin
    sel          = reg_select(PADDR);
    apb_setup    = PSEL && !PENABLE;
    apb_write    = PSEL && PENABLE && pready_reg && PWRITE;
    pready_next  = apb_setup;
    pslverr_next = apb_setup && (sel == 4'h0);
    prdata_next  = prdata_reg;
    if (apb_setup) begin
      prdata_next = 32'h0000_0000;
      if (!PWRITE && sel[0] && limit_valid_reg) begin
        prdata_next[15:0] = limit_reg;
      end else if (!PWRITE && sel[1]) begin
        prdata_next[15:0] = sp_reg;
      end else if (!PWRITE && sel[2]) begin
        prdata_next[stack_guard_pkg::FLAG_N-1:0] = flags_reg;
      end else if (!PWRITE && sel[3]) begin
        prdata_next[stack_guard_pkg::FLAG_N-1:0] = prot_reg;
      end
    end
    limit_next       = limit_reg;
    limit_valid_next = limit_valid_reg;
    prot_next        = prot_reg;
    if (apb_write && sel[0]) begin
      limit_next       = {PWDATA[15:1], 1'b0};
      limit_valid_next = 1'b1;
    end
    if (apb_write && sel[3]) begin
      prot_next = PWDATA[stack_guard_pkg::FLAG_N-1:0];
    end
    flag_hit[stack_guard_pkg::FLAG_OVF] = ovf_hit;
    flag_hit[stack_guard_pkg::FLAG_UNF] = unf_hit;
    flag_clr = (apb_write && sel[2]) ? PWDATA[stack_guard_pkg::FLAG_N-1:0] : '0;
  end

  // Sticky error flags, write one to clear; a new hit wins over the clear.
  for (genvar i = 0; i < stack_guard_pkg::FLAG_N; i++) begin : g_flag
    always_comb begin
      flags_next[i] = flag_hit[i] || (flags_reg[i] && !flag_clr[i]);
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_reg      <= '0;
      pready_reg      <= 1'b0;
      pslverr_reg     <= 1'b0;
      limit_valid_reg <= 1'b0;
      prot_reg        <= '0;
      flags_reg       <= '0;
    end else begin
      prdata_reg      <= prdata_next;
      pready_reg      <= pready_next;
      pslverr_reg     <= pslverr_next;
      limit_valid_reg <= limit_valid_next;
      prot_reg        <= prot_next;
      flags_reg       <= flags_next;
    end
  end

  // The limit itself is deliberately left without reset.
  always_ff @(posedge REF_CLK) begin
    limit_reg <= limit_next;
  end

  ram_segment_gate u_gate (
    .clk     (REF_CLK),
    .rst_n   (RESETN),
    .access  (DATA_ACCESS),
    .addr    (DATA_ADDR),
    .pc      (PC),
    .boot_en (prot_reg[stack_guard_pkg::PROT_BOOT]),
    .seg_en  (prot_reg[stack_guard_pkg::PROT_SEG]),
    .deny    (ACCESS_DENY)
  );

  assign PRDATA    = prdata_reg;
  assign PREADY    = pready_reg;
  assign PSLVERR   = pslverr_reg;
  assign STACK_PTR = sp_reg;
  assign BUSY      = busy_reg;
  assign MEM_WR    = mem_wr_reg;
  assign MEM_RD    = mem_rd_reg;
  assign MEM_ADDR  = mem_addr_reg;
  assign MEM_WDATA = mem_wdata_reg;
  assign TRAP_REQ  = trap_reg;

  property p_sp_write;
    @(posedge REF_CLK) disable iff (!RESETN)
      !busy_reg && !OP_VALID && SP_WR |=> STACK_PTR == {$past(SP_WDATA[15:1]), 1'b0};
  endproperty
  a_sp_write: assert property (p_sp_write) else $error("Pointer write lost.");

  property p_push;
    @(posedge REF_CLK) disable iff (!RESETN)
      !busy_reg && OP_VALID && OP_KIND == stack_guard_pkg::OP_PUSH
      |=> MEM_WR && MEM_ADDR == $past(sp_reg)
      && STACK_PTR == MEM_ADDR + stack_guard_pkg::WORD_STEP;
  endproperty
  a_push: assert property (p_push) else $error("Push order wrong.");

  property p_pop;
    @(posedge REF_CLK) disable iff (!RESETN)
      !busy_reg && OP_VALID && OP_KIND == stack_guard_pkg::OP_POP
      |=> MEM_RD && MEM_ADDR == $past(sp_reg) - stack_guard_pkg::WORD_STEP
      && STACK_PTR == MEM_ADDR;
  endproperty
  a_pop: assert property (p_pop) else $error("Pop order wrong.");

  property p_call_msb;
    @(posedge REF_CLK) disable iff (!RESETN)
      !busy_reg && OP_VALID && OP_KIND == stack_guard_pkg::OP_PUSH
      && PUSH_SRC == stack_guard_pkg::SRC_CALL
      |=> BUSY ##1 MEM_WR && MEM_WDATA[15:7] == 9'h000;
  endproperty
  a_call_msb: assert property (p_call_msb) else $error("Call push top bit set.");

  property p_exc_status;
    @(posedge REF_CLK) disable iff (!RESETN)
      !busy_reg && OP_VALID && OP_KIND == stack_guard_pkg::OP_PUSH
      && PUSH_SRC == stack_guard_pkg::SRC_EXC
      |=> ##1 MEM_WR && MEM_WDATA[15:8] == $past(STATUS_LOW, 2);
  endproperty
  a_exc_status: assert property (p_exc_status) else $error("Status byte missing.");

  property p_limit_lsb;
    @(posedge REF_CLK) disable iff (!RESETN)
      PSEL && !PENABLE && !PWRITE && PADDR == stack_guard_pkg::REG_LIMIT |=> !PRDATA[0];
  endproperty
  a_limit_lsb: assert property (p_limit_lsb) else $error("Limit bit zero reads one.");

  property p_at_limit;
    @(posedge REF_CLK) disable iff (!RESETN)
      !busy_reg && OP_VALID && OP_KIND == stack_guard_pkg::OP_PUSH && limit_valid_reg
      && sp_reg == limit_reg && sp_reg >= stack_guard_pkg::SFR_FLOOR
      |=> (!TRAP_REQ) and ((OP_VALID && OP_KIND == stack_guard_pkg::OP_PUSH && !BUSY)
      |=> TRAP_REQ);
  endproperty
  a_at_limit: assert property (p_at_limit) else $error("Limit trap misplaced.");

  property p_underflow;
    @(posedge REF_CLK) disable iff (!RESETN)
      !busy_reg && OP_VALID && OP_KIND == stack_guard_pkg::OP_POP
      && sp_reg <= stack_guard_pkg::SFR_FLOOR && sp_reg >= stack_guard_pkg::WORD_STEP
      |=> TRAP_REQ;
  endproperty
  a_underflow: assert property (p_underflow) else $error("Underflow not trapped.");

  property p_trap_cause;
    @(posedge REF_CLK) disable iff (!RESETN)
      TRAP_REQ |-> $past(ea_valid) && ($past(flag_hit) != '0);
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("Trap without cause.");

endmodule // stack_limit_guard
